// >>> core/gfc_pkg.sv
// Purpose: Shared constants of the gyro filter and threshold configuration bank
// Assumes: Byte wide register port, one clock domain
// Notes: Cutoffs in mHz, sensitivity in micro dps per LSB
package gfc_pkg;
  // ****************************************
  // Register offsets and reset values
  // ****************************************
  localparam logic [7:0] FILTER_RANGE_CONTROL_ADDR = 8'h0D;
  localparam logic [7:0] THRESHOLD_EVENT_CONFIG_ADDR = 8'h0E;
  localparam logic [7:0] THRESHOLD_EVENT_SOURCE_ADDR = 8'h0F;
  localparam logic [7:0] FILTER_RANGE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_EVENT_CONFIG_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_EVENT_CONFIG_MASK = 8'h0F;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BW_MSB = 7;
  localparam int BW_LSB = 6;
  localparam int WIRE_BIT = 5;
  localparam int HPSEL_MSB = 4;
  localparam int HPSEL_LSB = 3;
  localparam int HPEN_BIT = 2;
  localparam int FS_MSB = 1;
  localparam int FS_LSB = 0;
  localparam int LATCH_BIT = 3;
  localparam int Z_EN_BIT = 2;
  localparam int Y_EN_BIT = 1;
  localparam int X_EN_BIT = 0;
  localparam int EA_BIT = 6;
  // ****************************************
  // Operating modes and data rates
  // ****************************************
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_READY = 2'h1;
  localparam logic [1:0] MODE_ACTIVE = 2'h2;
  localparam logic [2:0] ODR_12P5_HZ = 3'h6;
  localparam logic [2:0] ODR_25_HZ = 3'h5;
  // ****************************************
  // Table bases at 800 Hz
  // ****************************************
  localparam logic [17:0] LPF_BASE_MHZ = 18'h3E800;
  localparam logic [13:0] HPF_BASE_00_MHZ = 14'h3A98;
  localparam logic [13:0] HPF_BASE_01_MHZ = 14'h1E14;
  localparam logic [13:0] HPF_BASE_10_MHZ = 14'h0F3C;
  localparam logic [13:0] HPF_BASE_11_MHZ = 14'h07BC;
  localparam logic [11:0] RANGE_BASE_DPS = 12'h7D0;
  localparam logic [16:0] SENS_BASE_UDPS = 17'h0F424;
endpackage

// >>> core/gfc_axis_detector.sv
// Purpose: One axis of the rate threshold detector with debounce and latch
// Assumes: Sample strobe is one cycle, rate is two's complement
// Notes: Set wins over a clear on read in the same cycle
`timescale 1ns/100ps
module gfc_axis_detector #(
  parameter int RATE_W = 16,
  parameter int CNT_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic restart_in,
  input wire logic sample_in,
  input wire logic enable_in,
  input wire logic latch_in,
  input wire logic clear_in,
  input wire logic signed [RATE_W-1:0] rate_in,
  input wire logic [RATE_W-1:0] threshold_in,
  input wire logic [CNT_W-1:0] count_in,
  output logic flag_out,
  output logic polarity_out
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic flag_next;
  logic pol_next;
  wire logic [RATE_W-1:0] abs_rate = rate_in[RATE_W-1] ? RATE_W'(-rate_in) : rate_in;
  wire logic above = abs_rate > threshold_in;
  wire logic held = latch_in && flag_out;
  // Counter runs while the rate sits on the side opposite the flag
  wire logic wants_change = above != flag_out;
  wire logic debounced = cnt_reg >= count_in;

  always_comb begin
    cnt_next = cnt_reg;
    flag_next = flag_out;
    pol_next = polarity_out;
    if (!enable_in || restart_in) begin
      cnt_next = '0;
      flag_next = 1'b0;
      pol_next = 1'b0;
    end else begin
      if (clear_in) begin
        flag_next = 1'b0;
        pol_next = 1'b0;
      end
      if (sample_in) begin
        if (!held) begin
          pol_next = rate_in[RATE_W-1];
        end
        if (!wants_change || held) begin
          cnt_next = '0;
        end else if (debounced) begin
          flag_next = above;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
      flag_out <= 1'b0;
      polarity_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      flag_out <= flag_next;
      polarity_out <= pol_next;
    end
  end
endmodule

// >>> core/gfc_config_bank.sv
// Purpose: Filter, range and rate threshold configuration registers
// Assumes: Serial engine outside presents byte reads and writes on one clock
// Notes: Read data appears one cycle after the read strobe
// ****************************************
// What this block does
// - Bandwidth field bits 7:6 picks low-pass cutoff scaled by data rate.
// - Bit 5 clear gives 4-wire serial, set gives 3-wire shared data pin.
// - Bits 4:3 pick high-pass cutoff from a table of bases, scaled by rate.
// - Bit 2 enables high-pass on output and threshold detector data.
// - High-pass state restarts on mode change, rate change or zero-rate bit.
// - Bits 1:0 pick full-scale range and matching sensitivity.
// - Detector state resets on Standby or Ready to Active.
// - Bit 3 makes threshold event flags latch.
// - Bits 2:0 enable Z, Y, X detection; disabled axis never flags.
// - Reading the event source clears latched flags.
// - Axis flag rises after rate stays above threshold for debounce count.
// ****************************************
`timescale 1ns/100ps
module gfc_config_bank #(
  parameter int RATE_W = 16,
  parameter int CNT_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [1:0] op_mode_in,
  input wire logic [2:0] output_data_rate_in,
  input wire logic zero_rate_ctrl_in,
  input wire logic sample_in,
  input wire logic signed [RATE_W-1:0] x_rate_in,
  input wire logic signed [RATE_W-1:0] y_rate_in,
  input wire logic signed [RATE_W-1:0] z_rate_in,
  input wire logic [RATE_W-1:0] rate_threshold_value_in,
  input wire logic [CNT_W-1:0] threshold_debounce_count_in,
  output logic [1:0] lowpass_bandwidth_sel_out,
  output logic serial_wire_count_sel_out,
  output logic [1:0] highpass_cutoff_sel_out,
  output logic highpass_enable_out,
  output logic [1:0] full_scale_sel_out,
  output logic [17:0] lowpass_cutoff_mhz_out,
  output logic lowpass_cutoff_valid_out,
  output logic [13:0] highpass_cutoff_mhz_out,
  output logic [11:0] range_dps_out,
  output logic [16:0] sensitivity_udps_out,
  output logic highpass_restart_out,
  output logic detector_restart_out,
  output logic [7:0] threshold_event_source_out
);
  import gfc_pkg::*;

  // ****************************************
  // Registers and decode
  // ****************************************
  logic [7:0] filter_range_control_reg;
  logic [7:0] threshold_event_config_reg;
  logic [1:0] mode_prev_reg;
  logic [2:0] odr_prev_reg;
  logic zero_prev_reg;
  logic [7:0] rdata_next;
  logic [2:0] axis_flag;
  logic [2:0] axis_pol;
  wire logic wr_frc = reg_write_in && reg_addr_in == FILTER_RANGE_CONTROL_ADDR;
  wire logic wr_tec = reg_write_in && reg_addr_in == THRESHOLD_EVENT_CONFIG_ADDR;
  wire logic rd_src = reg_read_in && reg_addr_in == THRESHOLD_EVENT_SOURCE_ADDR;
  wire logic latch_on = threshold_event_config_reg[LATCH_BIT];
  wire logic [2:0] axis_en = threshold_event_config_reg[Z_EN_BIT:X_EN_BIT];
  wire logic to_active = op_mode_in == MODE_ACTIVE &&
    (mode_prev_reg == MODE_STANDBY || mode_prev_reg == MODE_READY);
  wire logic zero_rise = zero_rate_ctrl_in && !zero_prev_reg;
  wire logic hp_restart = op_mode_in != mode_prev_reg || output_data_rate_in != odr_prev_reg ||
    zero_rise;
  wire logic ea_flag = |axis_flag;
  wire logic [7:0] source_value = {1'b0, ea_flag, axis_flag[2], axis_pol[2], axis_flag[1], axis_pol[1],
    axis_flag[0], axis_pol[0]};

  // ****************************************
  // Cutoff and range tables
  // ****************************************
  wire logic [1:0] bw = filter_range_control_reg[BW_MSB:BW_LSB];
  wire logic [1:0] hps = filter_range_control_reg[HPSEL_MSB:HPSEL_LSB];
  wire logic [1:0] fs = filter_range_control_reg[FS_MSB:FS_LSB];
  // Cutoffs scale with rate: one halving per rate step below 800 Hz
  wire logic [2:0] bw_shift = bw[1] ? 3'h2 : {2'h0, bw[0]};
  // Four bit sum keeps the carry that a three bit index would lose
  wire logic [3:0] lpf_shift = {1'b0, output_data_rate_in} + {1'b0, bw_shift};
  wire logic [17:0] lpf_value = LPF_BASE_MHZ >> lpf_shift;
  wire logic lpf_valid = !((bw != 2'h0 && output_data_rate_in == ODR_12P5_HZ) ||
    (bw[1] && output_data_rate_in == ODR_25_HZ));
  wire logic [13:0] hpf_base = hpf_base_of(hps);
  wire logic [13:0] hpf_value = hpf_base >> output_data_rate_in;
  wire logic [11:0] range_value = RANGE_BASE_DPS >> fs;
  wire logic [16:0] sens_value = SENS_BASE_UDPS >> fs;

  // Codes are not exact powers of two, hence a table of bases
  function automatic logic [13:0] hpf_base_of(input logic [1:0] sel);
    logic [13:0] v;
    unique case (sel)
      2'h0: v = HPF_BASE_00_MHZ;
      2'h1: v = HPF_BASE_01_MHZ;
      2'h2: v = HPF_BASE_10_MHZ;
      2'h3: v = HPF_BASE_11_MHZ;
    endcase
    return v;
  endfunction

  always_comb begin
    unique case (reg_addr_in)
      FILTER_RANGE_CONTROL_ADDR: rdata_next = filter_range_control_reg;
      THRESHOLD_EVENT_CONFIG_ADDR: rdata_next = threshold_event_config_reg & THRESHOLD_EVENT_CONFIG_MASK;
      THRESHOLD_EVENT_SOURCE_ADDR: rdata_next = source_value;
      default: rdata_next = 8'h00;
    endcase
  end

  // ****************************************
  // Storage
  // ****************************************
  // No mode gating on writes: the host owns that timing
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      filter_range_control_reg <= FILTER_RANGE_CONTROL_RESET;
      threshold_event_config_reg <= THRESHOLD_EVENT_CONFIG_RESET;
    end else begin
      if (wr_frc) begin
        filter_range_control_reg <= reg_wdata_in;
      end
      if (wr_tec) begin
        threshold_event_config_reg <= reg_wdata_in & THRESHOLD_EVENT_CONFIG_MASK;
      end
    end
  end

  // ****************************************
  // Read data, event source and restarts
  // ****************************************
  // Restarts are registered pulses, one cycle after the change
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_prev_reg <= MODE_STANDBY;
      odr_prev_reg <= 3'h0;
      zero_prev_reg <= 1'b0;
      reg_rdata_out <= 8'h00;
      highpass_restart_out <= 1'b0;
      detector_restart_out <= 1'b0;
      threshold_event_source_out <= 8'h00;
    end else begin
      mode_prev_reg <= op_mode_in;
      odr_prev_reg <= output_data_rate_in;
      zero_prev_reg <= zero_rate_ctrl_in;
      if (reg_read_in) begin
        reg_rdata_out <= rdata_next;
      end
      highpass_restart_out <= hp_restart;
      detector_restart_out <= to_active;
      threshold_event_source_out <= source_value;
    end
  end

  // ****************************************
  // Field copies and table outputs
  // ****************************************
  // Tables follow the rate input one cycle later, no mode gating
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lowpass_bandwidth_sel_out <= 2'h0;
      serial_wire_count_sel_out <= 1'b0;
      highpass_cutoff_sel_out <= 2'h0;
      highpass_enable_out <= 1'b0;
      full_scale_sel_out <= 2'h0;
      lowpass_cutoff_mhz_out <= 18'h00000;
      lowpass_cutoff_valid_out <= 1'b0;
      highpass_cutoff_mhz_out <= 14'h0000;
      range_dps_out <= 12'h000;
      sensitivity_udps_out <= 17'h00000;
    end else begin
      lowpass_bandwidth_sel_out <= bw;
      serial_wire_count_sel_out <= filter_range_control_reg[WIRE_BIT];
      highpass_cutoff_sel_out <= hps;
      highpass_enable_out <= filter_range_control_reg[HPEN_BIT];
      full_scale_sel_out <= fs;
      lowpass_cutoff_mhz_out <= lpf_valid ? lpf_value : 18'h00000;
      lowpass_cutoff_valid_out <= lpf_valid;
      highpass_cutoff_mhz_out <= hpf_value;
      range_dps_out <= range_value;
      sensitivity_udps_out <= sens_value;
    end
  end

  // ****************************************
  // Axis detectors
  // ****************************************
  wire logic signed [RATE_W-1:0] axis_rate [3] = '{x_rate_in, y_rate_in, z_rate_in};

  for (genvar a = 0; a < 3; a++) begin : g_axis
    gfc_axis_detector #(
      .RATE_W(RATE_W),
      .CNT_W(CNT_W)
    ) u_det (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .restart_in(to_active),
      .sample_in(sample_in),
      .enable_in(axis_en[a]),
      .latch_in(latch_on),
      .clear_in(rd_src && latch_on),
      // Same index as the enable bit and the flag, X at 0
      .rate_in(axis_rate[a]),
      .threshold_in(rate_threshold_value_in),
      .count_in(threshold_debounce_count_in),
      .flag_out(axis_flag[a]),
      .polarity_out(axis_pol[a])
    );
  end
endmodule

// >>> testbench/gfc_config_bank_props.sv
// Purpose: Port checks of the configuration bank
// Assumes: One clock, reset async active high
// Notes: Field and table outputs trail a write by two edges
`timescale 1ns/100ps
module gfc_config_bank_props import gfc_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [1:0] op_mode_in,
  input wire logic [2:0] output_data_rate_in,
  input wire logic zero_rate_ctrl_in,
  input wire logic [1:0] lowpass_bandwidth_sel_out,
  input wire logic serial_wire_count_sel_out,
  input wire logic highpass_enable_out,
  input wire logic [1:0] highpass_cutoff_sel_out,
  input wire logic [1:0] full_scale_sel_out,
  input wire logic [16:0] sensitivity_udps_out,
  input wire logic [11:0] range_dps_out,
  input wire logic highpass_restart_out,
  input wire logic detector_restart_out,
  input wire logic [7:0] threshold_event_source_out
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire logic w0d = reg_write_in && reg_addr_in == FILTER_RANGE_CONTROL_ADDR;
  a_bw_field: assert property (w0d |-> ##2 lowpass_bandwidth_sel_out == $past(reg_wdata_in[7:6], 2))
    else $error("bandwidth field wrong");
  a_wire_field: assert property (w0d |-> ##2 serial_wire_count_sel_out == $past(reg_wdata_in[5], 2))
    else $error("wire mode field wrong");
  a_hpen_field: assert property (w0d |-> ##2 highpass_enable_out == $past(reg_wdata_in[2], 2))
    else $error("highpass enable wrong");
  a_range_fs: assert property (w0d |-> ##2 range_dps_out == (RANGE_BASE_DPS >> $past(reg_wdata_in[1:0], 2)))
    else $error("range wrong");
  a_hpsel_field: assert property (w0d |-> ##2 highpass_cutoff_sel_out == $past(reg_wdata_in[4:3], 2))
    else $error("highpass cutoff select wrong");
  a_fs_field: assert property (w0d |-> ##2 full_scale_sel_out == $past(reg_wdata_in[1:0], 2))
    else $error("full scale field wrong");
  a_sens_fs: assert property (w0d |-> ##2
    sensitivity_udps_out == (SENS_BASE_UDPS >> $past(reg_wdata_in[1:0], 2))) else $error("sensitivity wrong");
  a_reserved_zero: assert property (reg_read_in && reg_addr_in == THRESHOLD_EVENT_CONFIG_ADDR |=>
    reg_rdata_out[7:4] == 4'h0) else $error("reserved bits not zero");
  a_det_restart: assert property (op_mode_in == MODE_ACTIVE && $past(op_mode_in) != MODE_ACTIVE |=>
    detector_restart_out) else $error("detector restart missing");
  a_hp_restart: assert property ($changed(op_mode_in) || $changed(output_data_rate_in) ||
    $rose(zero_rate_ctrl_in) |=> highpass_restart_out) else $error("highpass restart missing");
  a_active_or: assert property (threshold_event_source_out[7:6] == {1'b0,
    |{threshold_event_source_out[5], threshold_event_source_out[3], threshold_event_source_out[1]}})
    else $error("event active flag wrong");
  cover property (detector_restart_out);
  cover property (threshold_event_source_out[6]);
  cover property (w0d);
endmodule

// >>> testbench/gfc_host_model.sv
// Purpose: Host side of the register port
// Assumes: Strobes launched just after a rising edge
// Notes: Released address and data show the inverse
`timescale 1ns/100ps
module gfc_host_model import gfc_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_write_out,
  output logic reg_read_out,
  output logic [1:0] op_mode_out
);
  // ****************************************
  // Bus tasks
  // ****************************************
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
    op_mode_out = MODE_STANDBY;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    op_mode_out <= MODE_STANDBY; // Config touched in standby only
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_write_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_write_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_read_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_read_out <= 1'b0;
    reg_addr_out <= ~a;
    @(posedge ref_clk_in);
    q = reg_rdata_in;
  endtask
  task automatic go(input logic [1:0] m);
    @(posedge ref_clk_in);
    op_mode_out <= m;
  endtask
endmodule

// >>> testbench/gfc_config_bank_tb.sv
// Purpose: Self-checking bench of the configuration bank
// Assumes: Host model drives the register port
// Notes: Reset reads first, then table rows, detector cases after
`timescale 1ns/100ps
module gfc_config_bank_tb;
  import gfc_pkg::*;
  typedef struct packed {logic [2:0] rs; logic [7:0] a, d, q; logic [11:0] rng; logic [17:0] lpf;
    logic [13:0] hpf;} gfc_row_s;
  // ****************************************
  // Signals and table
  // ****************************************
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic zr = 1'b0;
  logic smp = 1'b0;
  logic [2:0] rsel = 3'h0;
  logic signed [15:0] xr = 16'sh0000;
  logic signed [15:0] yr = 16'sh0000;
  logic [7:0] addr, wdata, rdata, rv, src;
  logic wr, rd, lv;
  logic [1:0] mode;
  logic [11:0] rng;
  logic [17:0] lpf;
  logic [13:0] hpf;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  gfc_row_s rows [8] = '{'{3'h0, 8'h0D, 8'h00, 8'h00, 12'h7D0, 18'h3E800, 14'h3A98},
    '{3'h6, 8'h0D, 8'hC0, 8'hC0, 12'h7D0, 18'h00000, 14'h00EA},
    '{3'h6, 8'h0D, 8'h1B, 8'h1B, 12'h0FA, 18'h00FA0, 14'h001E},
    '{3'h5, 8'h0D, 8'h55, 8'h55, 12'h3E8, 18'h00FA0, 14'h0079},
    '{3'h1, 8'h0D, 8'hAA, 8'hAA, 12'h1F4, 18'h07D00, 14'h0F0A},
    '{3'h1, 8'h0E, 8'hFF, 8'h0F, 12'h1F4, 18'h07D00, 14'h0F0A},
    '{3'h1, 8'h0F, 8'hFF, 8'h00, 12'h1F4, 18'h07D00, 14'h0F0A},
    '{3'h1, 8'h3C, 8'h5A, 8'h00, 12'h1F4, 18'h07D00, 14'h0F0A}};
  always #2 ref_clk_in = ~ref_clk_in;
  gfc_host_model gfc_host_model_inst (.ref_clk_in(ref_clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_write_out(wr), .reg_read_out(rd), .op_mode_out(mode));
  gfc_config_bank gfc_config_bank_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .op_mode_in(mode),
    .output_data_rate_in(rsel), .zero_rate_ctrl_in(zr), .sample_in(smp), .x_rate_in(xr), .y_rate_in(yr),
    .z_rate_in(16'sh0000), .rate_threshold_value_in(16'h000A), .threshold_debounce_count_in(8'h02),
    .lowpass_bandwidth_sel_out(), .serial_wire_count_sel_out(), .highpass_cutoff_sel_out(),
    .highpass_enable_out(), .full_scale_sel_out(), .lowpass_cutoff_mhz_out(lpf),
    .lowpass_cutoff_valid_out(lv), .highpass_cutoff_mhz_out(hpf), .range_dps_out(rng),
    .sensitivity_udps_out(), .highpass_restart_out(), .detector_restart_out(),
    .threshold_event_source_out(src));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic samp(input logic signed [15:0] x, input logic signed [15:0] y);
    xr <= x;
    yr <= y;
    smp <= 1'b1;
    @(posedge ref_clk_in);
    smp <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard, the whole run needs well under a thousand cycles
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    gfc_host_model_inst.rd(FILTER_RANGE_CONTROL_ADDR, rv);
    chk("reset ctrl", 18'h0, 18'(rv));
    gfc_host_model_inst.rd(THRESHOLD_EVENT_CONFIG_ADDR, rv);
    chk("reset cfg", 18'h0, 18'(rv));
    chk("reset range", 18'h7D0, 18'(rng));
    zr <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      rsel <= rows[i].rs;
      gfc_host_model_inst.wr(rows[i].a, rows[i].d);
      gfc_host_model_inst.rd(rows[i].a, rv);
      chk("readback", 18'(rows[i].q), 18'(rv));
      chk("range", 18'(rows[i].rng), 18'(rng));
      chk("lowpass", rows[i].lpf, lpf);
      chk("lowpass valid", 18'(rows[i].lpf != 18'h0), 18'(lv));
      chk("highpass", 18'(rows[i].hpf), 18'(hpf));
    end
    $display("test table done");
    gfc_host_model_inst.wr(THRESHOLD_EVENT_CONFIG_ADDR, 8'h09);
    gfc_host_model_inst.go(MODE_ACTIVE);
    // Restart pulse would swallow a sample taken in its own cycle
    @(posedge ref_clk_in);
    repeat (2) samp(-16'sd20, 16'sd50);
    chk("source early", 18'h01, 18'(src));
    samp(-16'sd20, 16'sd50);
    chk("source set", 18'h43, 18'(src));
    repeat (3) samp(16'sd0, 16'sd0);
    chk("source held", 18'h43, 18'(src));
    gfc_host_model_inst.rd(THRESHOLD_EVENT_SOURCE_ADDR, rv);
    @(posedge ref_clk_in);
    chk("source read", 18'h43, 18'(rv));
    chk("source cleared", 18'h0, 18'(src));
    $display("test detector done");
    gfc_host_model_inst.wr(THRESHOLD_EVENT_CONFIG_ADDR, 8'h02);
    gfc_host_model_inst.go(MODE_ACTIVE);
    @(posedge ref_clk_in);
    repeat (3) samp(16'sd0, 16'sd50);
    chk("unlatched set", 18'h48, 18'(src));
    repeat (2) samp(16'sd0, 16'sd0);
    chk("unlatched hold", 18'h48, 18'(src));
    samp(16'sd0, 16'sd0);
    chk("unlatched clear", 18'h0, 18'(src));
    $display("test unlatched done");
    gfc_host_model_inst.wr(FILTER_RANGE_CONTROL_ADDR, 8'hFF);
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    chk("reset mid range", 18'h0, 18'(rng));
    chk("reset mid source", 18'h0, 18'(src));
    rst_in <= 1'b0;
    gfc_host_model_inst.rd(FILTER_RANGE_CONTROL_ADDR, rv);
    chk("reset mid ctrl", 18'h0, 18'(rv));
    chk("reset mid range after", 18'h7D0, 18'(rng));
    chk("reset mid valid", 18'h1, 18'(lv));
    $display("test mid reset done");
    summarize();
  end
endmodule
bind gfc_config_bank gfc_config_bank_props gfc_config_bank_props_inst (.ref_clk_in, .rst_in, .reg_addr_in,
  .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .op_mode_in, .output_data_rate_in,
  .zero_rate_ctrl_in, .lowpass_bandwidth_sel_out, .serial_wire_count_sel_out, .highpass_enable_out,
  .highpass_cutoff_sel_out, .full_scale_sel_out, .sensitivity_udps_out,
  .range_dps_out, .highpass_restart_out, .detector_restart_out, .threshold_event_source_out);
